// >>> rtl/i2sap_top.sv
// Audio serial port: registers, FIFOs, clock divider and serial engine
`timescale 1ns/10ps

module i2sap_fifo #(
   parameter int WIDTH = 32,
   parameter int DEPTH = 16,
   parameter int LW    = 5
) (
   input  wire logic             clock_i,   // System clock
   input  wire logic             sys_rst_i, // Async reset
   input  wire logic             push_i,    // Write request
   input  wire logic [WIDTH-1:0] data_i,    // Write data
   input  wire logic             pop_i,     // Read request
   input  wire logic             flush_i,   // Discard all
   output logic      [WIDTH-1:0] data_o,    // Head entry
   output logic      [LW-1:0]    level_o,   // Entry count
   output logic                  full_o,    // No room
   output logic                  empty_o    // Nothing held
);
   localparam int AW = $clog2(DEPTH);
   logic [WIDTH-1:0] mem [DEPTH];
   logic [AW-1:0]    wr_ptr;
   logic [AW-1:0]    rd_ptr;
   logic             do_push;
   logic             do_pop;

   // Flush wins over a same-cycle push or pop
   assign do_push = push_i & ~full_o & ~flush_i;
   assign do_pop  = pop_i & ~empty_o & ~flush_i;
   assign full_o  = level_o == LW'(DEPTH);
   assign empty_o = level_o == '0;
   assign data_o  = mem[rd_ptr];

   // Storage
   always_ff @(posedge clock_i) begin
      if (do_push) begin
         mem[wr_ptr] <= data_i;
      end
   end

   // Pointers and level
   always_ff @(posedge clock_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         wr_ptr  <= '0;
         rd_ptr  <= '0;
         level_o <= '0;
      end else if (flush_i) begin
         wr_ptr  <= '0;
         rd_ptr  <= '0;
         level_o <= '0;
      end else begin
         if (do_push) wr_ptr <= wr_ptr + AW'(1);
         if (do_pop) rd_ptr <= rd_ptr + AW'(1);
         level_o <= level_o + LW'(do_push) - LW'(do_pop);
      end
   end
endmodule

module i2sap_top (
   input  wire logic        clock_i,              // 200 MHz system clock
   input  wire logic        sys_rst_i,            // Async reset, high
   input  wire logic [31:0] reg_addr_i,           // Register address
   input  wire logic [31:0] reg_wdata_i,          // Write data
   input  wire logic        reg_wr_i,             // Write strobe
   input  wire logic        reg_rd_i,             // Read strobe
   output logic      [31:0] reg_rdata_o,          // Read data, next cycle
   input  wire logic        codec_clock_input_i,  // Clock from codec pin
   output logic             codec_master_clock_o, // Codec root clock
   input  wire logic        bit_clock_i,          // Bit clock pin in
   output logic             bit_clock_o,          // Bit clock pin out
   output logic             bit_clock_oe_o,       // Bit clock drive
   input  wire logic        channel_clock_i,      // Channel clock pin in
   output logic             channel_clock_o,      // Channel clock pin out
   output logic             channel_clock_oe_o,   // Channel clock drive
   input  wire logic        serial_data_i,        // Receive data pin
   output logic             serial_data_o         // Transmit data pin
);
   localparam int PIN_CCI = 0;
   localparam int PIN_BCK = 1;
   localparam int PIN_LRC = 2;
   localparam int PIN_SDI = 3;
   localparam int LB = i2sap_pkg::LEVEL_BITS;

   i2sap_pkg::i2sap_bus_s  bus;
   i2sap_pkg::i2sap_mode_s mode;
   logic        run;
   logic        psc_en;
   logic [9:0]  psc_val;
   logic [9:0]  psc_cnt;
   logic [3:0]  pin_s1, pin_s2, pin_s3;
   logic        is_slave, ext_src, src_tick, mclk_tick;
   logic [7:0]  half, bclk_cnt;
   logic [5:0]  slot, lp, pos, next_pos;
   logic [4:0]  width, rx_cnt;
   logic        bclk, lr, next_lr, fall, rise, tx_en, rx_en;
   logic [15:0] tx_sh, tx_right, tx_word, rx_sh, rx_left, rx_val;
   logic        tx_flush, rx_flush, tx_push, tx_pop, rx_push, rx_pop, rx_done;
   logic [31:0] tx_head, rx_head, next_rdata;
   logic [LB-1:0] tx_level, rx_level;
   logic        tx_full, tx_empty, rx_full, rx_empty;

   // Divider from codec clock ticks to half bit periods
   function automatic logic [7:0] half_ticks(input logic [1:0] r, input logic [1:0] b);
      int rm;
      int bm;
      rm = (r == 2'h0) ? i2sap_pkg::ROOT_R0 : (r == 2'h1) ? i2sap_pkg::ROOT_R1 :
           (r == 2'h2) ? i2sap_pkg::ROOT_R2 : i2sap_pkg::ROOT_R3;
      bm = (b == 2'h0) ? i2sap_pkg::BIT_R0 : (b == 2'h1) ? i2sap_pkg::BIT_R1 :
           (b == 2'h2) ? i2sap_pkg::BIT_R2 : i2sap_pkg::BIT_R3;
      return 8'(rm / bm);
   endfunction

   // Bit position at which a channel word starts
   function automatic logic [5:0] load_pos(input i2sap_pkg::i2sap_fmt_e f, input logic [5:0] s,
                                           input logic [4:0] w);
      unique case (f)
         i2sap_pkg::FMT_I2S: return 6'h01;
         i2sap_pkg::FMT_MSB: return 6'h00;
         i2sap_pkg::FMT_LSB: return (s > 6'(w)) ? s - 6'(w) : 6'h00;
         default:            return 6'h00;
      endcase
   endfunction

   // Bus request bundle and register decodes
   assign bus      = '{addr: reg_addr_i, wdata: reg_wdata_i, wr: reg_wr_i, rd: reg_rd_i};
   assign tx_flush = bus.wr & bus.addr == i2sap_pkg::FIFO_CTRL_ADDR & bus.wdata[i2sap_pkg::TX_FLUSH_BIT];
   assign rx_flush = bus.wr & bus.addr == i2sap_pkg::FIFO_CTRL_ADDR & bus.wdata[i2sap_pkg::RX_FLUSH_BIT];
   assign tx_push  = bus.wr & bus.addr == i2sap_pkg::TX_DATA_ADDR;
   assign rx_pop   = bus.rd & bus.addr == i2sap_pkg::RX_DATA_ADDR;

   // Configuration registers
   always_ff @(posedge clock_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         mode    <= i2sap_pkg::i2sap_mode_s'(i2sap_pkg::MODE_RESET);
         run     <= 1'b0;
         psc_en  <= 1'b0;
         psc_val <= i2sap_pkg::PSC_RESET;
      end else if (bus.wr) begin
         if (bus.addr == i2sap_pkg::MODE_ADDR)
            mode <= i2sap_pkg::i2sap_mode_s'(bus.wdata[i2sap_pkg::MODE_BITS-1:0]);
         if (bus.addr == i2sap_pkg::CONTROL_ADDR)
            run <= bus.wdata[i2sap_pkg::CTRL_RUN_BIT];
         if (bus.addr == i2sap_pkg::PRESCALER_ADDR) begin
            psc_en  <= bus.wdata[i2sap_pkg::PSC_EN_BIT];
            psc_val <= bus.wdata[i2sap_pkg::PSC_BITS-1:0];
         end
      end
   end

   // Read mux; unmapped and write-only addresses read zero
   always_comb begin
      next_rdata = 32'h0000_0000;
      unique case (bus.addr)
         i2sap_pkg::CONTROL_ADDR: begin
            next_rdata[i2sap_pkg::CTRL_RUN_BIT]  = run;
            next_rdata[i2sap_pkg::CTRL_CHAN_BIT] = lr;
            next_rdata[i2sap_pkg::CTRL_TXE_BIT]  = tx_empty;
            next_rdata[i2sap_pkg::CTRL_RXE_BIT]  = rx_empty;
            next_rdata[i2sap_pkg::CTRL_TXF_BIT]  = tx_full;
            next_rdata[i2sap_pkg::CTRL_RXF_BIT]  = rx_full;
         end
         i2sap_pkg::MODE_ADDR: next_rdata[i2sap_pkg::MODE_BITS-1:0] = mode;
         i2sap_pkg::FIFO_CTRL_ADDR: begin
            next_rdata[i2sap_pkg::TX_LEVEL_LSB +: LB] = tx_level;
            next_rdata[i2sap_pkg::RX_LEVEL_LSB +: LB] = rx_level;
         end
         i2sap_pkg::PRESCALER_ADDR: begin
            next_rdata[i2sap_pkg::PSC_EN_BIT]         = psc_en;
            next_rdata[i2sap_pkg::PSC_BITS-1:0]       = psc_val;
         end
         i2sap_pkg::RX_DATA_ADDR: next_rdata = rx_empty ? 32'h0000_0000 : rx_head;
         default: next_rdata = 32'h0000_0000;
      endcase
   end

   // Read data stands one cycle after the strobe only
   always_ff @(posedge clock_i or posedge sys_rst_i) begin
      if (sys_rst_i) reg_rdata_o <= 32'h0000_0000;
      else reg_rdata_o <= bus.rd ? next_rdata : 32'h0000_0000;
   end

   // Two-stage synchronisers, third stage for edge detection
   always_ff @(posedge clock_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         pin_s1 <= 4'h0;
         pin_s2 <= 4'h0;
         pin_s3 <= 4'h0;
      end else begin
         pin_s1 <= {serial_data_i, channel_clock_i, bit_clock_i, codec_clock_input_i};
         pin_s2 <= pin_s1;
         pin_s3 <= pin_s2;
      end
   end

   // Clock source and role selection
   assign is_slave  = mode.role[1];
   assign ext_src   = mode.src_sel | (mode.role == 2'h1);
   assign src_tick  = ext_src ? (pin_s2[PIN_CCI] & ~pin_s3[PIN_CCI]) : 1'b1;
   assign mclk_tick = src_tick & (~psc_en | psc_cnt == psc_val);
   assign tx_en     = mode.direction == i2sap_pkg::TX_ONLY | mode.direction == i2sap_pkg::DUPLEX;
   assign rx_en     = mode.direction == i2sap_pkg::RX_ONLY | mode.direction == i2sap_pkg::DUPLEX;
   assign width     = mode.narrow ? 5'(i2sap_pkg::NARROW_BITS) : 5'(i2sap_pkg::WIDE_BITS);
   assign half      = half_ticks(mode.root, mode.bitr);
   // Channel slot is half the bit clock ratio, in bits
   assign slot      = (mode.bitr == 2'h0) ? 6'(i2sap_pkg::BIT_R0 / 2) :
                      (mode.bitr == 2'h1) ? 6'(i2sap_pkg::BIT_R1 / 2) :
                      (mode.bitr == 2'h2) ? 6'(i2sap_pkg::BIT_R2 / 2) : 6'(i2sap_pkg::BIT_R3 / 2);
   assign lp        = load_pos(mode.format, slot, width);

   // Prescaler counts source ticks up to the divider value
   always_ff @(posedge clock_i or posedge sys_rst_i) begin
      if (sys_rst_i) psc_cnt <= 10'h000;
      else if (bus.wr & bus.addr == i2sap_pkg::PRESCALER_ADDR) psc_cnt <= 10'h000; // New value restarts count
      else if (~psc_en | mclk_tick) psc_cnt <= 10'h000;
      else if (src_tick) psc_cnt <= psc_cnt + 10'h001;
   end

   // Master clocks: codec root clock and bit clock
   always_ff @(posedge clock_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         codec_master_clock_o <= 1'b0;
         bclk_cnt             <= 8'h00;
         bclk                 <= 1'b0;
      end else if (~run | is_slave) begin
         codec_master_clock_o <= 1'b0;
         bclk_cnt             <= 8'h00;
         bclk                 <= 1'b0;
      end else if (mclk_tick) begin
         codec_master_clock_o <= ~codec_master_clock_o;
         bclk_cnt             <= (bclk_cnt == half - 8'h01) ? 8'h00 : bclk_cnt + 8'h01;
         if (bclk_cnt == half - 8'h01) bclk <= ~bclk;
      end
   end

   // Bit clock edges from the master divider or the slave pin
   assign fall = run & (is_slave ? (~pin_s2[PIN_BCK] & pin_s3[PIN_BCK])
                                 : (mclk_tick & bclk_cnt == half - 8'h01 & bclk));
   assign rise = run & (is_slave ? (pin_s2[PIN_BCK] & ~pin_s3[PIN_BCK])
                                 : (mclk_tick & bclk_cnt == half - 8'h01 & ~bclk));

   // Next bit position and channel level at a falling edge
   always_comb begin
      next_lr  = lr;
      next_pos = pos + 6'h01;
      if (is_slave) begin
         if (pin_s2[PIN_LRC] != lr) begin
            next_lr  = pin_s2[PIN_LRC];
            next_pos = 6'h00;
         end
      end else if (pos == slot - 6'h01) begin
         next_lr  = ~lr;
         next_pos = 6'h00;
      end
   end

   // Channel clock and bit position
   always_ff @(posedge clock_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         lr  <= i2sap_pkg::LR_RESET;
         pos <= 6'h00;
      end else if (~run) begin
         pos <= 6'h00;
      end else if (fall) begin
         lr  <= next_lr;
         pos <= next_pos;
      end
   end

   // Transmit word choice: left pops a pair, right uses its saved half
   assign tx_pop  = fall & tx_en & next_pos == lp & (next_lr == mode.polarity) & ~tx_empty;
   assign tx_word = (next_lr == mode.polarity) ? (tx_empty ? 16'h0000 : tx_head[15:0]) : tx_right;

   // Transmit shifter, MSB first, zeros after the word
   always_ff @(posedge clock_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         tx_sh         <= 16'h0000;
         tx_right      <= 16'h0000;
         serial_data_o <= 1'b0;
      end else if (~run | ~tx_en | tx_flush) begin
         tx_sh         <= 16'h0000;
         tx_right      <= 16'h0000;
         serial_data_o <= 1'b0;
      end else if (fall) begin
         if (next_pos == lp) begin
            if (next_lr == mode.polarity) tx_right <= tx_empty ? 16'h0000 : tx_head[31:16];
            tx_sh         <= (mode.narrow ? {tx_word[7:0], 8'h00} : tx_word) << 1;
            serial_data_o <= mode.narrow ? tx_word[7] : tx_word[15];
         end else begin
            tx_sh         <= tx_sh << 1;
            serial_data_o <= tx_sh[15];
         end
      end
   end

   // Receive completion at a rising edge
   assign rx_val  = {rx_sh[14:0], pin_s2[PIN_SDI]};
   assign rx_done = rise & rx_en & ((pos == lp) ? 1'b0 : (rx_cnt != 5'h00 & rx_cnt == width - 5'h01));
   assign rx_push = rx_done & (lr != mode.polarity);

   // Receive shifter and left-channel hold
   always_ff @(posedge clock_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         rx_sh   <= 16'h0000;
         rx_cnt  <= 5'h00;
         rx_left <= 16'h0000;
      end else if (~run | ~rx_en | rx_flush) begin
         rx_sh  <= 16'h0000;
         rx_cnt <= 5'h00;
      end else if (rise) begin
         if (pos == lp) begin
            rx_sh  <= {15'h0000, pin_s2[PIN_SDI]};
            rx_cnt <= 5'h01;
         end else if (rx_done) begin
            rx_cnt <= 5'h00;
            if (lr == mode.polarity) rx_left <= rx_val;
         end else if (rx_cnt != 5'h00) begin
            rx_sh  <= rx_val;
            rx_cnt <= rx_cnt + 5'h01;
         end
      end
   end

   // Pin drivers: the master drives both clocks
   always_ff @(posedge clock_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         bit_clock_o        <= 1'b0;
         bit_clock_oe_o     <= 1'b0;
         channel_clock_o    <= 1'b0;
         channel_clock_oe_o <= 1'b0;
      end else begin
         bit_clock_o        <= bclk;
         bit_clock_oe_o     <= run & ~is_slave;
         channel_clock_o    <= lr;
         channel_clock_oe_o <= run & ~is_slave;
      end
   end

   // Transmit FIFO
   i2sap_fifo #(.WIDTH(32), .DEPTH(i2sap_pkg::FIFO_DEPTH), .LW(LB)) u_tx_fifo (
      .clock_i  (clock_i),
      .sys_rst_i(sys_rst_i),
      .push_i   (tx_push),
      .data_i   (bus.wdata),
      .pop_i    (tx_pop),
      .flush_i  (tx_flush),
      .data_o   (tx_head),
      .level_o  (tx_level),
      .full_o   (tx_full),
      .empty_o  (tx_empty)
   );

   // Receive FIFO, pair packed right high and left low
   i2sap_fifo #(.WIDTH(32), .DEPTH(i2sap_pkg::FIFO_DEPTH), .LW(LB)) u_rx_fifo (
      .clock_i  (clock_i),
      .sys_rst_i(sys_rst_i),
      .push_i   (rx_push),
      .data_i   ({rx_val, rx_left}),
      .pop_i    (rx_pop),
      .flush_i  (rx_flush),
      .data_o   (rx_head),
      .level_o  (rx_level),
      .full_o   (rx_full),
      .empty_o  (rx_empty)
   );

   // Checks
   sequence tx_flush_s;
      reg_wr_i && reg_addr_i == i2sap_pkg::FIFO_CTRL_ADDR && reg_wdata_i[i2sap_pkg::TX_FLUSH_BIT];
   endsequence
   sequence rx_flush_s;
      reg_wr_i && reg_addr_i == i2sap_pkg::FIFO_CTRL_ADDR && reg_wdata_i[i2sap_pkg::RX_FLUSH_BIT];
   endsequence

   tx_flush_empty_a: assert property (@(posedge clock_i) disable iff (sys_rst_i)
      tx_flush_s |=> tx_level == '0 && tx_empty) else $error("tx flush left data");
   rx_flush_empty_a: assert property (@(posedge clock_i) disable iff (sys_rst_i)
      rx_flush_s |=> rx_level == '0 && rx_empty) else $error("rx flush left data");
   tx_level_range_a: assert property (@(posedge clock_i) disable iff (sys_rst_i)
      tx_level <= LB'(i2sap_pkg::FIFO_DEPTH)) else $error("tx level above depth");
   rx_level_range_a: assert property (@(posedge clock_i) disable iff (sys_rst_i)
      rx_level <= LB'(i2sap_pkg::FIFO_DEPTH)) else $error("rx level above depth");
   tx_push_count_a: assert property (@(posedge clock_i) disable iff (sys_rst_i)
      tx_push && !tx_full && !tx_pop && !tx_flush |=> tx_level == $past(tx_level) + LB'(1))
      else $error("tx push not counted");
   rx_pop_count_a: assert property (@(posedge clock_i) disable iff (sys_rst_i)
      rx_pop && !rx_empty && !rx_push && !rx_flush |=> rx_level == $past(rx_level) - LB'(1))
      else $error("rx pop not counted");
   idle_no_drive_a: assert property (@(posedge clock_i) disable iff (sys_rst_i)
      !run ##1 !run |-> !bit_clock_oe_o && !channel_clock_oe_o && !fall) else $error("idle port drives");
   divider_bound_a: assert property (@(posedge clock_i) disable iff (sys_rst_i)
      psc_en |-> psc_cnt <= psc_val) else $error("prescaler past limit");
   channel_read_a: assert property (@(posedge clock_i) disable iff (sys_rst_i)
      reg_rd_i && reg_addr_i == i2sap_pkg::CONTROL_ADDR |=> reg_rdata_o[i2sap_pkg::CTRL_CHAN_BIT] == $past(lr))
      else $error("channel indication wrong");
   slave_no_drive_a: assert property (@(posedge clock_i) disable iff (sys_rst_i)
      mode.role[1] ##1 mode.role[1] |-> !bit_clock_oe_o) else $error("slave drives bit clock");
endmodule

// >>> rtl/i2sap_pkg.sv
// Constants and types of the audio serial port
package i2sap_pkg;
   // Register byte addresses
   localparam logic [31:0] CONTROL_ADDR   = 32'h5500_0000;
   localparam logic [31:0] MODE_ADDR      = 32'h5500_0004;
   localparam logic [31:0] FIFO_CTRL_ADDR = 32'h5500_0008;
   localparam logic [31:0] PRESCALER_ADDR = 32'h5500_000C;
   localparam logic [31:0] TX_DATA_ADDR   = 32'h5500_0010;
   localparam logic [31:0] RX_DATA_ADDR   = 32'h5500_0014;
   // Control register fields
   localparam int CTRL_RUN_BIT  = 0;
   localparam int CTRL_RXF_BIT  = 7;
   localparam int CTRL_TXF_BIT  = 8;
   localparam int CTRL_RXE_BIT  = 9;
   localparam int CTRL_TXE_BIT  = 10;
   localparam int CTRL_CHAN_BIT = 11;
   // Mode register holds bits 12..0
   localparam int MODE_BITS = 13;
   localparam logic [12:0] MODE_RESET = 13'h0000;
   // FIFO control fields
   localparam int TX_FLUSH_BIT = 15;
   localparam int TX_LEVEL_LSB = 8;
   localparam int RX_FLUSH_BIT = 7;
   localparam int RX_LEVEL_LSB = 0;
   // Prescaler fields
   localparam int PSC_EN_BIT = 15;
   localparam int PSC_BITS   = 10;
   localparam logic [9:0] PSC_RESET = 10'h000;
   // Data path sizes
   localparam int FIFO_DEPTH = 16;
   localparam int LEVEL_BITS = 5;
   localparam int WIDE_BITS  = 16;
   localparam int NARROW_BITS = 8;
   localparam logic LR_RESET = 1'b1;
   // Clock ratios to the sample rate
   localparam int ROOT_R0 = 256;
   localparam int ROOT_R1 = 512;
   localparam int ROOT_R2 = 384;
   localparam int ROOT_R3 = 768;
   localparam int BIT_R0  = 32;
   localparam int BIT_R1  = 48;
   localparam int BIT_R2  = 16;
   localparam int BIT_R3  = 24;
   // Direction and framing codes
   typedef enum logic [1:0] {TX_ONLY = 2'h0, RX_ONLY = 2'h1, DUPLEX = 2'h2, DIR_RSVD = 2'h3} i2sap_dir_e;
   typedef enum logic [1:0] {FMT_I2S = 2'h0, FMT_MSB = 2'h1, FMT_LSB = 2'h2, FMT_RSVD = 2'h3} i2sap_fmt_e;
   // Mode register layout, msb first
   typedef struct packed {
      logic       src_sel;
      logic [1:0] role;
      i2sap_dir_e direction;
      logic       polarity;
      i2sap_fmt_e format;
      logic [1:0] root;
      logic [1:0] bitr;
      logic       narrow;
   } i2sap_mode_s;
   // One register bus request
   typedef struct packed {
      logic [31:0] addr;
      logic [31:0] wdata;
      logic        wr;
      logic        rd;
   } i2sap_bus_s;
endpackage

// >>> testbench/i2sap_codec.sv
// Behavioural audio codec that echoes the port's transmit stream
`timescale 1ns/10ps
module i2sap_codec (
   input  wire logic clock_i,  // System clock, paces the idle pattern
   input  wire logic bclk_i,   // Bit clock on the wire
   input  wire logic active_i, // Port drives the bit clock
   input  wire logic sdata_i,  // Data from the port
   output logic      sdata_o   // Data towards the port
);
   logic held;
   // Known start so the idle pattern really moves
   initial begin
      held = 1'b0;
      sdata_o = 1'b0;
   end
   // Receiver samples on the rising bit clock
   always @(posedge bclk_i) begin
      held <= sdata_i;
   end
   // Transmitter changes on the falling bit clock; an idle line keeps moving
   always @(negedge bclk_i or posedge clock_i) begin
      if (!active_i) begin
         sdata_o <= ~sdata_o;
      end else if (!bclk_i) begin
         sdata_o <= held;
      end
   end
endmodule

// >>> testbench/tb_i2s_audio_serial_port.sv
// Self-checking bench for the audio serial port
`timescale 1ns/10ps
`define CHK(g, e) begin num_checks++; if ((g) !== (e)) begin bad_count++; $display("CHECK FAILED %0t got %h exp %h", $time, g, e); end end
module tb_i2s_audio_serial_port;
   logic        clock_i = 1'b0;
   logic        sys_rst_i = 1'b1;
   logic [31:0] reg_addr_i = 32'h0;
   logic [31:0] reg_wdata_i = 32'h0;
   logic        reg_wr_i = 1'b0;
   logic        reg_rd_i = 1'b0;
   logic [31:0] reg_rdata_o;
   logic        mclk, bclk, bclk_oe, lrclk, lrclk_oe, sd_out, sd_in;
   logic        idle_pat = 1'b0;
   logic [31:0] d;
   logic [12:0] m;
   logic [31:0] psc_tab [4] = '{32'h0, 32'h8001, 32'h0001, 32'h0};
   logic [31:0] mod_tab [4] = '{32'h0, 32'h0, 32'h0, 32'h000C};
   int          per_tab [4] = '{16, 32, 16, 64};
   int          bad_count = 0;
   int          num_checks = 0;
   int          cyc = 0;
   int          last_rise = 0;
   int          prev_rise = 0;
   int          n;
   // Clock, cycle count and a moving pattern for undriven pins
   always #2.5 clock_i = ~clock_i;
   always @(posedge clock_i) begin
      idle_pat <= ~idle_pat;
      cyc <= cyc + 1;
   end
   // Times of the last two rising bit clock edges
   always @(posedge bclk) begin
      prev_rise <= last_rise;
      last_rise <= cyc;
   end
   i2sap_top i_i2sap_top (
      .clock_i(clock_i), .sys_rst_i(sys_rst_i), .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i),
      .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o), .codec_clock_input_i(idle_pat),
      .codec_master_clock_o(mclk), .bit_clock_i(bclk_oe ? bclk : idle_pat), .bit_clock_o(bclk),
      .bit_clock_oe_o(bclk_oe), .channel_clock_i(lrclk_oe ? lrclk : idle_pat), .channel_clock_o(lrclk),
      .channel_clock_oe_o(lrclk_oe), .serial_data_i(sd_in), .serial_data_o(sd_out));
   i2sap_codec i_i2sap_codec (.clock_i(clock_i), .bclk_i(bclk), .active_i(bclk_oe), .sdata_i(sd_out), .sdata_o(sd_in));
   // One register write cycle
   task automatic wr(input logic [31:0] a, input logic [31:0] v);
      @(posedge clock_i);
      reg_addr_i <= a;
      reg_wdata_i <= v;
      reg_wr_i <= 1'b1;
      @(posedge clock_i);
      reg_wr_i <= 1'b0;
   endtask
   // One register read cycle; data taken in the following cycle
   task automatic rd(input logic [31:0] a, output logic [31:0] v);
      @(posedge clock_i);
      reg_addr_i <= a;
      reg_rd_i <= 1'b1;
      @(posedge clock_i);
      reg_rd_i <= 1'b0;
      #1 v = reg_rdata_o;
   endtask
   // Verdict and end of run
   task automatic close_out;
      $display("checks %0d mismatches %0d", num_checks, bad_count);
      if (bad_count == 0 && num_checks > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask
   // Main sequence
   initial begin
      repeat (20) @(posedge clock_i);
      sys_rst_i <= 1'b0;
      rd(i2sap_pkg::MODE_ADDR, d);
      `CHK(d, 32'h0)
      rd(i2sap_pkg::FIFO_CTRL_ADDR, d);
      `CHK(d, 32'h0)
      rd(i2sap_pkg::CONTROL_ADDR, d);
      `CHK(d, 32'h0000_0E00)
      rd(32'h5500_0020, d);
      `CHK(d, 32'h0)
      for (n = 0; n < 4; n++) begin
         m = {n[0], n[1:0], 2'(n % 3), ~n[0], 2'((n + 1) % 3), n[1:0], ~n[1:0], n[1]};
         wr(i2sap_pkg::MODE_ADDR, {19'h0, m});
         rd(i2sap_pkg::MODE_ADDR, d);
         `CHK(d, {19'h0, m})
      end
      wr(i2sap_pkg::PRESCALER_ADDR, 32'h0000_83FF);
      rd(i2sap_pkg::PRESCALER_ADDR, d);
      `CHK(d, 32'h0000_83FF)
      wr(i2sap_pkg::MODE_ADDR, 32'h0);
      // Fill the transmit FIFO past full, then flush it
      for (n = 0; n < 17; n++) wr(i2sap_pkg::TX_DATA_ADDR, 32'h1111_0000 + 32'(n));
      rd(i2sap_pkg::FIFO_CTRL_ADDR, d);
      `CHK(d, 32'h0000_1000)
      rd(i2sap_pkg::CONTROL_ADDR, d);
      `CHK(d, 32'h0000_0B00)
      rd(i2sap_pkg::TX_DATA_ADDR, d);
      `CHK(d, 32'h0)
      wr(i2sap_pkg::FIFO_CTRL_ADDR, 32'h0);
      rd(i2sap_pkg::FIFO_CTRL_ADDR, d);
      `CHK(d, 32'h0000_1000)
      wr(i2sap_pkg::FIFO_CTRL_ADDR, 32'h0000_8000);
      rd(i2sap_pkg::FIFO_CTRL_ADDR, d);
      `CHK(d, 32'h0)
      rd(i2sap_pkg::RX_DATA_ADDR, d);
      `CHK(d, 32'h0)
      // Bit clock period for several divider and ratio settings
      for (n = 0; n < 4; n++) begin
         wr(i2sap_pkg::CONTROL_ADDR, 32'h0);
         wr(i2sap_pkg::PRESCALER_ADDR, psc_tab[n]);
         wr(i2sap_pkg::MODE_ADDR, mod_tab[n]);
         wr(i2sap_pkg::CONTROL_ADDR, 32'h1);
         repeat (400) @(posedge clock_i);
         `CHK(bclk_oe, 1'b1)
         `CHK(lrclk_oe, 1'b1)
         `CHK(last_rise - prev_rise, per_tab[n])
      end
      wr(i2sap_pkg::CONTROL_ADDR, 32'h0);
      repeat (50) @(posedge clock_i);
      `CHK(bclk_oe, 1'b0)
      wr(i2sap_pkg::MODE_ADDR, 32'h0000_0800);
      wr(i2sap_pkg::CONTROL_ADDR, 32'h1);
      repeat (50) @(posedge clock_i);
      `CHK(bclk_oe, 1'b0)
      // Duplex loop through the codec in 8-bit mode
      wr(i2sap_pkg::CONTROL_ADDR, 32'h0);
      wr(i2sap_pkg::PRESCALER_ADDR, 32'h0);
      wr(i2sap_pkg::MODE_ADDR, 32'h0000_0201);
      for (n = 0; n < 4; n++) wr(i2sap_pkg::TX_DATA_ADDR, 32'h00A5_005A);
      wr(i2sap_pkg::CONTROL_ADDR, 32'h1);
      repeat (2500) @(posedge clock_i);
      wr(i2sap_pkg::CONTROL_ADDR, 32'h0);
      rd(i2sap_pkg::FIFO_CTRL_ADDR, d);
      `CHK(d[4:0] != 5'h0, 1'b1)
      rd(i2sap_pkg::RX_DATA_ADDR, d);
      `CHK(d & 32'hFF00_FF00, 32'h0)
      wr(i2sap_pkg::FIFO_CTRL_ADDR, 32'h0000_0080);
      rd(i2sap_pkg::FIFO_CTRL_ADDR, d);
      `CHK(d[4:0], 5'h0)
      close_out();
   end
endmodule
